// file: hdl/dnw_top.sv
// Purpose: network-facing status, speed, control and reference words of a drive
// Assumes: one 40 MHz clock REF_CLK; drive flags arrive from outside the domain
// Notes:   network port may write; local port (keypad, embedded logic) only reads
`include "dnw_consts.svh"
`default_nettype none
// Functional notes
// - one read-only 16-bit status word
// - bit 1 shows run command given
// - bit 2 shows emergency override active
// - bit 5 shows second ramp pair
// - bit 6 shows configuration state
// - bit 7 shows alarm state
// - bit 8 shows motor running
// - bit 9 shows inverter enabled
// - bit 10 shows forward rotation
// - bit 12 shows remote control
// - bit 13 shows undervoltage
// - bit 15 shows any fault
// - speed word signed, 8192 is rated
// - reverse rotation reads negative speed
// - network speed values saturate at limits
// - control word written by network only
// - bit 0 ramps up or ramps down
// - bit 1 enables or cuts power
// - bit 2 follows or opposes reference sign
// - bit 4 selects remote or local
// - bit 7 resets an existing fault
// - speed reference network-writable, same scale
// - direction combines bit 2 and sign
module dnw_top #(
  parameter int MAG_W = 18
) (
  // clock and reset
  input  wire logic             REF_CLK,
  input  wire logic             RST,
  // network parameter port
  input  wire logic             NET_SEL,
  input  wire logic             NET_WE,
  input  wire logic [9:0]       NET_PARAM,
  input  wire logic [15:0]      NET_WDATA,
  output logic      [15:0]      NET_RDATA,
  output logic                  NET_ACK,
  output logic                  NET_ERR,
  // local read-only parameter port
  input  wire logic             LOC_SEL,
  input  wire logic             LOC_WE,
  input  wire logic [9:0]       LOC_PARAM,
  output logic      [15:0]      LOC_RDATA,
  output logic                  LOC_ACK,
  output logic                  LOC_ERR,
  // drive state flags, asynchronous levels
  input  wire logic             RUN_CMD_GIVEN,
  input  wire logic             OVERRIDE_ACTIVE,
  input  wire logic             SECOND_RAMP_ACTIVE,
  input  wire logic             CONFIG_STATE,
  input  wire logic             ALARM_ACTIVE,
  input  wire logic             MOTOR_RUNNING,
  input  wire logic             DRIVE_ENABLED,
  input  wire logic             MOTOR_FORWARD,
  input  wire logic             INCHING_ACTIVE,
  input  wire logic             REMOTE_ACTIVE,
  input  wire logic             UNDERVOLTAGE,
  input  wire logic             FAULT_PRESENT,
  // measured speed, same clock domain
  input  wire logic [MAG_W-1:0] SPEED_MAG,
  // commands to the motor control
  output logic                  RAMP_ENABLE,
  output logic                  GENERAL_ENABLE,
  output logic                  DIR_FORWARD,
  output logic                  INCHING_ENABLE,
  output logic                  REMOTE_SELECT,
  output logic                  SECOND_RAMP_SELECT,
  output logic                  FAULT_RESET,
  output logic signed [15:0]    SPEED_REF
);
  localparam int NFLAG = 12;

  logic [NFLAG-1:0]   flag_raw;
  logic [NFLAG-1:0]   flag;
  logic [15:0]        status_word;
  logic [15:0]        ctrl_reg;
  logic [15:0]        ctrl_next;
  logic [15:0]        sref_reg;
  logic               net_wr;
  logic               net_hit_ctrl;
  logic               net_hit_sref;

  dnw_sat_if #(.MAG_W(MAG_W)) sat ();

  // gather the drive flags for one synchroniser bank
  assign flag_raw = {FAULT_PRESENT, UNDERVOLTAGE, REMOTE_ACTIVE, INCHING_ACTIVE,
                     MOTOR_FORWARD, DRIVE_ENABLED, MOTOR_RUNNING, ALARM_ACTIVE,
                     CONFIG_STATE, SECOND_RAMP_ACTIVE, OVERRIDE_ACTIVE, RUN_CMD_GIVEN};

  dnw_sync #(.W(NFLAG)) u_sync (
    .clk (REF_CLK),
    .rst (RST),
    .d   (flag_raw),
    .q   (flag)
  );

  // status word assembly
  // reserved bits 0, 3, 4 and 14 stay zero
  always_comb begin
    status_word                       = 16'h0000;
    status_word[`DNW_ST_RUN_CMD]      = flag[0];
    status_word[`DNW_ST_FIRE]         = flag[1];
    status_word[`DNW_ST_RAMP2]        = flag[2];
    status_word[`DNW_ST_CONFIG]       = flag[3];
    status_word[`DNW_ST_ALARM]        = flag[4];
    status_word[`DNW_ST_RUNNING]      = flag[5];
    status_word[`DNW_ST_ENABLED]      = flag[6];
    status_word[`DNW_ST_FORWARD]      = flag[7];
    status_word[`DNW_ST_INCHING]      = flag[8];
    status_word[`DNW_ST_REMOTE]       = flag[9];
    status_word[`DNW_ST_UNDERVOLT]    = flag[10];
    status_word[`DNW_ST_FAULT]        = flag[11];
  end

  // signed speed word, magnitude scaled by caller
  assign sat.mag = SPEED_MAG;
  assign sat.rev = ~flag[7];

  dnw_speed_sat #(.MAG_W(MAG_W)) u_sat (
    .clk (REF_CLK),
    .rst (RST),
    .sat (sat)
  );

  // readback mux shared by both ports
  function automatic logic [16:0] read_word(input logic [9:0] idx, input logic [15:0] st,
                                            input logic [15:0] sp, input logic [15:0] cw,
                                            input logic [15:0] sr);
    if (idx == `DNW_IDX_STATUS) begin
      read_word = {1'b1, st};
    end else if (idx == `DNW_IDX_SPEED) begin
      read_word = {1'b1, sp};
    end else if (idx == `DNW_IDX_CTRL) begin
      read_word = {1'b1, cw};
    end else if (idx == `DNW_IDX_SREF) begin
      read_word = {1'b1, sr};
    end else begin
      read_word = 17'h00000; // unknown parameter
    end
  endfunction

  // write decode, network side only
  assign net_wr       = NET_SEL & NET_WE;
  assign net_hit_ctrl = net_wr & (NET_PARAM == `DNW_IDX_CTRL);
  assign net_hit_sref = net_wr & (NET_PARAM == `DNW_IDX_SREF);

  // reserved control bits dropped on write
  always_comb begin
    ctrl_next = ctrl_reg;
    if (net_hit_ctrl) begin
      ctrl_next = NET_WDATA & `DNW_CW_WMASK;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= `DNW_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sref_reg <= `DNW_SREF_RESET;
    end else if (net_hit_sref) begin
      sref_reg <= NET_WDATA;
    end
  end

  // network answer: writes to read-only or unknown words are refused
  always_ff @(posedge REF_CLK or posedge RST) begin
    logic [16:0] rw;
    if (RST) begin
      NET_RDATA <= 16'h0000;
      NET_ACK   <= 1'b0;
      NET_ERR   <= 1'b0;
    end else begin
      rw        = read_word(NET_PARAM, status_word, sat.word, ctrl_reg, sref_reg);
      NET_ACK   <= NET_SEL;
      NET_ERR   <= NET_SEL & (~rw[16] | (NET_WE & ~(net_hit_ctrl | net_hit_sref)));
      if (NET_SEL & ~NET_WE) begin
        NET_RDATA <= rw[15:0];
      end
    end
  end

  // local port reads only; any write attempt is refused
  always_ff @(posedge REF_CLK or posedge RST) begin
    logic [16:0] rl;
    if (RST) begin
      LOC_RDATA <= 16'h0000;
      LOC_ACK   <= 1'b0;
      LOC_ERR   <= 1'b0;
    end else begin
      rl        = read_word(LOC_PARAM, status_word, sat.word, ctrl_reg, sref_reg);
      LOC_ACK   <= LOC_SEL;
      LOC_ERR   <= LOC_SEL & (LOC_WE | ~rl[16]);
      if (LOC_SEL & ~LOC_WE) begin
        LOC_RDATA <= rl[15:0];
      end
    end
  end

  // command levels straight from the stored control word, SPEED_REF from the stored reference word
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RAMP_ENABLE        <= 1'b0;
      GENERAL_ENABLE     <= 1'b0;
      INCHING_ENABLE     <= 1'b0;
      REMOTE_SELECT      <= 1'b0;
      SECOND_RAMP_SELECT <= 1'b0;
      SPEED_REF          <= '0;
    end else begin
      RAMP_ENABLE        <= ctrl_reg[`DNW_CW_RAMP_EN];
      GENERAL_ENABLE     <= ctrl_reg[`DNW_CW_GEN_EN];
      INCHING_ENABLE     <= ctrl_reg[`DNW_CW_INCHING];
      REMOTE_SELECT      <= ctrl_reg[`DNW_CW_REMOTE];
      SECOND_RAMP_SELECT <= ctrl_reg[`DNW_CW_RAMP2];
      SPEED_REF          <= sref_reg;
    end
  end

  // direction from bit 2 and reference sign
  // zero reference counts as positive so bit 2 alone decides
  // bit 2 clear with a positive reference runs reverse
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      DIR_FORWARD <= 1'b0;
    end else begin
      DIR_FORWARD <= ctrl_reg[`DNW_CW_RUN_FWD] ^ sref_reg[15];
    end
  end

  // fault reset pulse on a write that sets bit 7 while a fault exists
  // a held bit does not repeat the pulse; rewrite it to reset again
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      FAULT_RESET <= 1'b0;
    end else begin
      FAULT_RESET <= net_hit_ctrl & NET_WDATA[`DNW_CW_FAULT_RST] & flag[11];
    end
  end
endmodule
`default_nettype wire

// file: hdl/dnw_consts.svh
// Purpose: constants of the drive network word bank
// Assumes: included by bare name from the modules; the package does not include it
// Notes:   parameter numbers double as the access index on both ports
`ifndef DNW_CONSTS_SVH
`define DNW_CONSTS_SVH

// parameter numbers of the four words
`define DNW_IDX_STATUS      10'h2a8
`define DNW_IDX_SPEED       10'h2a9
`define DNW_IDX_CTRL        10'h2ac
`define DNW_IDX_SREF        10'h2ad

// status word bit positions
`define DNW_ST_RUN_CMD      1
`define DNW_ST_FIRE         2
`define DNW_ST_RAMP2        5
`define DNW_ST_CONFIG       6
`define DNW_ST_ALARM        7
`define DNW_ST_RUNNING      8
`define DNW_ST_ENABLED      9
`define DNW_ST_FORWARD      10
`define DNW_ST_INCHING      11
`define DNW_ST_REMOTE       12
`define DNW_ST_UNDERVOLT    13
`define DNW_ST_FAULT        15

// control word bit positions
`define DNW_CW_RAMP_EN      0
`define DNW_CW_GEN_EN       1
`define DNW_CW_RUN_FWD      2
`define DNW_CW_INCHING      3
`define DNW_CW_REMOTE       4
`define DNW_CW_RAMP2        5
`define DNW_CW_FAULT_RST    7
`define DNW_CW_WMASK        16'h00bf

// reset values and scale
`define DNW_CTRL_RESET      16'h0000
`define DNW_SREF_RESET      16'h0000
`define DNW_RATED_SCALE     16'h2000
`define DNW_SAT_POS         16'h7fff
`define DNW_SAT_NEG         16'h8000

`endif

// file: hdl/dnw_pkg.sv
// Purpose: shared types of the drive network word bank
// Assumes: constants live in dnw_consts.svh
// Notes:   nothing here is imported; users write dnw_pkg::name
`default_nettype none
package dnw_pkg;
  // answer kind of one parameter access
  typedef enum logic [1:0] {
    DNW_ANS_IDLE = 2'b00,
    DNW_ANS_OK   = 2'b01,
    DNW_ANS_ERR  = 2'b10
  } dnw_ans_t;
  typedef logic signed [15:0] dnw_word_t;
endpackage
`default_nettype wire

// file: hdl/dnw_if.sv
// Purpose: carries the speed value to and from the saturating scaler
// Assumes: one clock, all signals synchronous
// Notes:   magnitude is unsigned, direction is a separate flag
`default_nettype none
interface dnw_sat_if #(parameter int MAG_W = 18);
  logic [MAG_W-1:0]   mag;
  logic               rev;
  dnw_pkg::dnw_word_t word;
  modport user (output mag, output rev, input word);
  modport scaler (input mag, input rev, output word);
endinterface
`default_nettype wire

// file: hdl/dnw_sync.sv
// Purpose: three-stage synchroniser for a group of level inputs
// Assumes: bits are independent levels from outside the clock domain
// Notes:   a change is taken only once stages two and three agree
`default_nettype none
module dnw_sync #(
  parameter int W = 12
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels in and filtered out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // shift chain; the first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // per bit: accept only a value seen twice in a row
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/dnw_speed_sat.sv
// Purpose: signs and saturates the measured speed into the network word
// Assumes: magnitude already uses the 8192 = rated frequency scale
// Notes:   registered output, one cycle of latency
`include "dnw_consts.svh"
`default_nettype none
module dnw_speed_sat #(
  parameter int MAG_W = 18
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // value path
  dnw_sat_if.scaler sat
);
  // clamp magnitude to the positive or negative limit
  function automatic logic [15:0] sat_word(input logic [MAG_W-1:0] m, input logic r);
    logic [MAG_W-1:0] lim;
    lim = MAG_W'({1'b0, `DNW_SAT_POS});
    if (!r) begin
      sat_word = (m > lim) ? `DNW_SAT_POS : m[15:0];
    end else if (m > lim) begin
      sat_word = `DNW_SAT_NEG; // reverse beyond range pins at the negative limit
    end else begin
      sat_word = 16'(-m[15:0]);
    end
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sat.word <= '0;
    end else begin
      sat.word <= sat_word(sat.mag, sat.rev);
    end
  end
endmodule
`default_nettype wire

// file: verification/dnw_top_props.sv
// Purpose: port-level checker for the drive network word bank
// Assumes: one clock REF_CLK, RST asynchronous and active high
// Notes:   bound to dnw_top after the module; command outputs lag a write by two edges, FAULT_RESET by one
`include "dnw_consts.svh"
`default_nettype none
module dnw_top_props (
  // clock and reset
  input wire logic               REF_CLK,
  input wire logic               RST,
  // network port
  input wire logic               NET_SEL,
  input wire logic               NET_WE,
  input wire logic [9:0]         NET_PARAM,
  input wire logic [15:0]        NET_WDATA,
  input wire logic [15:0]        NET_RDATA,
  input wire logic               NET_ACK,
  input wire logic               NET_ERR,
  // local port
  input wire logic               LOC_SEL,
  input wire logic               LOC_WE,
  input wire logic               LOC_ACK,
  input wire logic               LOC_ERR,
  // command outputs
  input wire logic               RAMP_ENABLE,
  input wire logic               GENERAL_ENABLE,
  input wire logic               DIR_FORWARD,
  input wire logic               FAULT_RESET,
  input wire logic signed [15:0] SPEED_REF
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // decoded requests on the network port
  logic wr_ctrl;
  logic wr_sref;
  logic wr_ro;
  logic rd_ctrl;
  logic rd_stat;
  assign wr_ctrl = NET_SEL && NET_WE && NET_PARAM == `DNW_IDX_CTRL;
  assign wr_sref = NET_SEL && NET_WE && NET_PARAM == `DNW_IDX_SREF;
  assign wr_ro = NET_SEL && NET_WE && (NET_PARAM == `DNW_IDX_STATUS ||
                                       NET_PARAM == `DNW_IDX_SPEED);
  assign rd_ctrl = NET_SEL && !NET_WE && NET_PARAM == `DNW_IDX_CTRL;
  assign rd_stat = NET_SEL && !NET_WE && NET_PARAM == `DNW_IDX_STATUS;

  a_ro_write_err:
    assert property (wr_ro |=> NET_ACK && NET_ERR) else $error("read-only write not refused");
  a_ack_cause:
    assert property (NET_ACK |-> $past(NET_SEL)) else $error("answer without request");
  a_loc_refuse:
    assert property (LOC_SEL && LOC_WE |=> LOC_ACK && LOC_ERR) else $error("local write taken");
  a_ctrl_apply:
    assert property (wr_ctrl |-> ##2 {14'h0, GENERAL_ENABLE, RAMP_ENABLE} ==
                     ($past(NET_WDATA, 2) & 16'h0003)) else $error("enables not applied");
  a_sref_apply:
    assert property (wr_sref |-> ##2 SPEED_REF == $past(NET_WDATA, 2))
      else $error("reference not applied");
  a_cmd_hold:
    assert property ((!(NET_SEL && NET_WE))[*2] |=>
                     $stable({RAMP_ENABLE, GENERAL_ENABLE, DIR_FORWARD, SPEED_REF}))
      else $error("commands moved without a write");
  a_fault_idle:
    assert property ((!NET_SEL)[*2] |=> !FAULT_RESET) else $error("fault reset without write");
  a_rdata_hold:
    assert property (!(NET_SEL && !NET_WE) |=> $stable(NET_RDATA)) else $error("read data moved");
  a_ctrl_rsvd:
    assert property ($past(rd_ctrl) |-> NET_ACK && (NET_RDATA & ~`DNW_CW_WMASK) == 16'h0000)
      else $error("reserved control bits set");
  a_stat_rsvd:
    assert property ($past(rd_stat) |-> (NET_RDATA & 16'h4019) == 16'h0000)
      else $error("reserved status bits set");
endmodule
bind dnw_top dnw_top_props u_props (.*);
`default_nettype wire

// file: verification/dnw_net_master.sv
// Purpose: network master standing on the far side of the parameter port
// Assumes: device takes a request on each rising edge that sees the select high
// Notes:   released write data is inverted so a stale value never looks valid
`default_nettype none
module dnw_net_master (
  // clock
  input  wire logic        clk,
  // parameter port towards the device
  output logic             sel,
  output logic             we,
  output logic [9:0]       param,
  output logic [15:0]      wdata,
  input  wire logic [15:0] rdata,
  input  wire logic        ack,
  input  wire logic        err
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle port at time zero
  initial begin
    sel = 1'b0;
    we = 1'b0;
    param = 10'h000;
    wdata = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [9:0] p, input logic [15:0] d,
                      output logic [15:0] q, output logic e);
    @(negedge clk);
    sel = 1'b1;
    we = w;
    param = p;
    wdata = d;
    @(negedge clk);
    sel = 1'b0;
    we = 1'b0;
    wdata = ~d;
    q = rdata;
    e = ack ? err : 1'bx;  // a missing answer never passes as a match
  endtask
endmodule
`default_nettype wire

// file: verification/dnw_top_test.sv
// Purpose: self-checking bench for the drive network word bank
// Assumes: inputs move on the falling edge; flags settle within six cycles
// Notes:   network traffic goes through the master model, local traffic from here
`include "dnw_consts.svh"
`default_nettype none
module dnw_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] PS = `DNW_IDX_STATUS;
  localparam logic [9:0] PV = `DNW_IDX_SPEED;
  localparam logic [9:0] PC = `DNW_IDX_CTRL;
  localparam logic [9:0] PR = `DNW_IDX_SREF;
  logic               clk, rst, lsel, lwe;
  logic        [9:0]  lpar;
  logic        [11:0] fl;
  logic        [17:0] mag;
  wire logic          nsel, nwe, nack, nerr, lack, lerr;
  wire logic   [9:0]  npar;
  wire logic   [15:0] nwd, nrd, lrd;
  wire logic   [6:0]  cmd;
  wire logic signed [15:0] sref;
  int                 miscompares, tests_run, cyc, n;
  int                 pos [12] = '{1, 2, 5, 6, 7, 8, 9, 10, 11, 12, 13, 15};
  logic        [15:0] dv [4] = '{16'h1000, 16'hf000, 16'h1000, 16'hf000};
  // expected speed words: rated forward, rated reverse, clamped forward, clamped reverse
  logic        [15:0] sv [4] = '{16'h2000, 16'he000, 16'h7fff, 16'h8000};

  dnw_net_master master (.clk(clk), .sel(nsel), .we(nwe), .param(npar), .wdata(nwd),
    .rdata(nrd), .ack(nack), .err(nerr));
  dnw_top uut (
    .REF_CLK(clk), .RST(rst), .NET_SEL(nsel), .NET_WE(nwe), .NET_PARAM(npar),
    .NET_WDATA(nwd), .NET_RDATA(nrd), .NET_ACK(nack), .NET_ERR(nerr), .LOC_SEL(lsel),
    .LOC_WE(lwe), .LOC_PARAM(lpar), .LOC_RDATA(lrd), .LOC_ACK(lack), .LOC_ERR(lerr),
    .RUN_CMD_GIVEN(fl[0]), .OVERRIDE_ACTIVE(fl[1]), .SECOND_RAMP_ACTIVE(fl[2]),
    .CONFIG_STATE(fl[3]), .ALARM_ACTIVE(fl[4]), .MOTOR_RUNNING(fl[5]),
    .DRIVE_ENABLED(fl[6]), .MOTOR_FORWARD(fl[7]), .INCHING_ACTIVE(fl[8]),
    .REMOTE_ACTIVE(fl[9]), .UNDERVOLTAGE(fl[10]), .FAULT_PRESENT(fl[11]),
    .SPEED_MAG(mag), .RAMP_ENABLE(cmd[0]), .GENERAL_ENABLE(cmd[1]), .DIR_FORWARD(cmd[2]),
    .INCHING_ENABLE(cmd[3]), .REMOTE_SELECT(cmd[4]), .SECOND_RAMP_SELECT(cmd[5]),
    .FAULT_RESET(cmd[6]), .SPEED_REF(sref));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask
  // network access with expected refusal flag and read value
  task automatic acc(input logic w, input logic [9:0] p, input logic [15:0] d,
                     input logic [15:0] eq, input logic ee);
    logic [15:0] q;
    logic        e;
    master.xfer(w, p, d, q, e);
    chk({15'h0, e}, {15'h0, ee});
    if (!w && !ee) chk(q, eq);
  endtask
  // local access; the answer is sampled one cycle after the request
  task automatic lacc(input logic w, input logic [9:0] p, input logic [15:0] eq,
                      input logic ee);
    @(negedge clk);
    lsel = 1'b1;
    lwe = w;
    lpar = p;
    @(negedge clk);
    lsel = 1'b0;
    lwe = 1'b0;
    chk({14'h0, lack, lerr}, {14'h0, 1'b1, ee});
    if (!w) chk(lrd, eq);
  endtask
  // counts fault reset pulses in the cycles after a fault reset write
  task automatic fpulse(input int exp);
    acc(1'b1, PC, 16'h0080, 16'h0, 1'b0);
    n = 0;
    repeat (3) begin
      if (cmd[6] !== 1'b0) n++;
      @(negedge clk);
    end
    chk(16'(n), 16'(exp));
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    lsel = 1'b0;
    lwe = 1'b0;
    lpar = 10'h000;
    fl = 12'h000;
    mag = 18'h00000;
    idle(16);
    rst = 1'b0;
    acc(1'b0, PC, 16'h0, 16'h0000, 1'b0);
    acc(1'b0, PR, 16'h0, 16'h0000, 1'b0);
    for (int i = 0; i < 12; i++) begin
      fl = 12'h001 << i;
      idle(6);
      acc(1'b0, PS, 16'h0, 16'h0001 << pos[i], 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      fl = {4'h0, ~i[0], 7'h00};
      mag = i[1] ? 18'd40000 : 18'd8192;
      idle(6);
      acc(1'b0, PV, 16'h0, sv[i], 1'b0);
    end
    fl = 12'h000;
    acc(1'b1, PS, 16'h1234, 16'h0, 1'b1);
    acc(1'b1, PV, 16'h0000, 16'h0, 1'b1);
    acc(1'b1, PC, 16'hffff, 16'h0, 1'b0);
    acc(1'b0, PC, 16'h0, 16'h00bf, 1'b0);
    idle(1);
    chk({10'h0, cmd[5:0]}, 16'h003f);
    lacc(1'b1, PC, 16'h0, 1'b1);
    lacc(1'b0, PC, 16'h00bf, 1'b0);
    acc(1'b1, PC, 16'h0000, 16'h0, 1'b0);
    idle(1);
    chk({10'h0, cmd[5:0]}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, PC, i[1] ? 16'h0000 : 16'h0004, 16'h0, 1'b0);
      acc(1'b1, PR, dv[i], 16'h0, 1'b0);
      idle(1);
      chk({15'h0, cmd[2]}, {15'h0, i[1] ^ ~i[0]});
      chk(sref, dv[i]);
    end
    fl = 12'h800;
    idle(6);
    lacc(1'b0, PS, 16'h8000, 1'b0);
    fpulse(1);
    fl = 12'h000;
    idle(6);
    fpulse(0);
    summarize();
  end
endmodule
`default_nettype wire
